//--- hdl/dotc_term_ctrl.v
// Termination controller for the command bus and data lanes of a low-power DRAM.
//
// Our own choices: the Avalon-MM interface to the registers and the register addresses.
`include "dotc_regs.vh"
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RULE1] Command bus strength from 3-bit code.
// [RULE2] Nonzero data code enables lane termination.
// [RULE3] Zero data code disables lane termination.
// [RULE4] Termination covers data, strobes, mask pin.
// [RULE5] Enabled lanes rest off until write command.
// [RULE6] Termination ends after the write burst.
// [RULE7] Power-down or self-refresh forces lanes off.
// [RULE8] Turn-on latency counts from second column command.
// [RULE9] Turn-on latency per speed bin table.
// [RULE10] Turn-off latency counts from second column command.
// [RULE11] Turn-off latency per speed bin table.
// [RULE12] Burst of 32 adds eight turn-off cycles.
// [RULE13] Turn-on analog window 1.5 to 3.5 ns. The code's output register adds one 5 ns clock instead.
// [RULE14] Turn-off analog window 1.5 to 3.5 ns. The code's output register adds one 5 ns clock instead.
// [RULE15] Strap low keeps command bus unterminated.
// [RULE16] Write leveling: strobes only, data off.
// [RULE17] Command bus termination off after reset.
// [RULE18] Code 111 is reserved, treated as off.
module dotc_term_ctrl #(
    parameter CODE_W = 3,
    parameter LAT_W = 6
) (
    input wire mclk,
    input wire srst,
    input wire clk_en,
    input wire [1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    input wire cmd_clk,
    input wire cas2_write,
    input wire power_down,
    input wire self_refresh,
    input wire cmd_bus_term_strap,
    output reg [CODE_W-1:0] ca_term_code,
    output reg [CODE_W-1:0] dq_term_code,
    output reg dqs_term_code_en,
    output reg dq_term_en,
    output reg dqs_term_en,
    output reg mask_inversion_pin_term_en
);

////////////////////////////////////////////////////////////////////////////////
// Timing helpers.

localparam integer TURN_MIN_CYC = (`DOTC_TURN_TIME_MIN_PS + `DOTC_CLK_PERIOD_PS - 1) / `DOTC_CLK_PERIOD_PS;
localparam integer TURN_MAX_CYC_RAW = `DOTC_TURN_TIME_MAX_PS / `DOTC_CLK_PERIOD_PS;
localparam integer TURN_MAX_CYC = (TURN_MAX_CYC_RAW < 1) ? 1 : TURN_MAX_CYC_RAW;

// One-hot states of the lane engine.
localparam [2:0] ST_IDLE = 3'h1;
localparam [2:0] ST_WAIT_ON = 3'h2;
localparam [2:0] ST_ON = 3'h4;
localparam [LAT_W-1:0] CNT_ZERO = {LAT_W{1'b0}};
localparam [LAT_W-1:0] CNT_ONE = {{(LAT_W-1){1'b0}}, 1'b1};

// A latency of zero marks a bin without a defined latency; lanes stay off there, except the strobes in write leveling.
function [LAT_W-1:0] on_lat;
    input [2:0] bin;
    input set_b;
    begin
        if (set_b) begin
            case (bin)
                `DOTC_BIN_800: on_lat = `DOTC_ON_B_800;
                `DOTC_BIN_1066: on_lat = `DOTC_ON_B_1066;
                `DOTC_BIN_1333: on_lat = `DOTC_ON_B_1333;
                `DOTC_BIN_1600: on_lat = `DOTC_ON_B_1600;
                `DOTC_BIN_1866: on_lat = `DOTC_ON_B_1866;
                `DOTC_BIN_2133: on_lat = `DOTC_ON_B_2133;
                default: on_lat = `DOTC_LAT_NA;
            endcase
        end else begin
            case (bin)
                `DOTC_BIN_800: on_lat = `DOTC_LAT_NA;
                `DOTC_BIN_1066: on_lat = `DOTC_ON_A_1066;
                `DOTC_BIN_1333: on_lat = `DOTC_ON_A_1333;
                `DOTC_BIN_1600: on_lat = `DOTC_ON_A_1600;
                `DOTC_BIN_1866: on_lat = `DOTC_ON_A_1866;
                `DOTC_BIN_2133: on_lat = `DOTC_ON_A_2133;
                default: on_lat = `DOTC_LAT_NA;
            endcase
        end
    end
endfunction

function [LAT_W-1:0] off_lat;
    input [2:0] bin;
    input set_b;
    begin
        if (set_b) begin
            case (bin)
                `DOTC_BIN_800: off_lat = `DOTC_OFF_B_800;
                `DOTC_BIN_1066: off_lat = `DOTC_OFF_B_1066;
                `DOTC_BIN_1333: off_lat = `DOTC_OFF_B_1333;
                `DOTC_BIN_1600: off_lat = `DOTC_OFF_B_1600;
                `DOTC_BIN_1866: off_lat = `DOTC_OFF_B_1866;
                `DOTC_BIN_2133: off_lat = `DOTC_OFF_B_2133;
                default: off_lat = `DOTC_LAT_NA;
            endcase
        end else begin
            case (bin)
                `DOTC_BIN_800: off_lat = `DOTC_LAT_NA;
                `DOTC_BIN_1066: off_lat = `DOTC_OFF_A_1066;
                `DOTC_BIN_1333: off_lat = `DOTC_OFF_A_1333;
                `DOTC_BIN_1600: off_lat = `DOTC_OFF_A_1600;
                `DOTC_BIN_1866: off_lat = `DOTC_OFF_A_1866;
                `DOTC_BIN_2133: off_lat = `DOTC_OFF_A_2133;
                default: off_lat = `DOTC_LAT_NA;
            endcase
        end
    end
endfunction

// The reserved code behaves as off so that a stray value never terminates a pin.
function code_valid;
    input [2:0] code;
    begin
        case (code)
            `DOTC_CODE_OFF: code_valid = 1'b0;
            `DOTC_CODE_RSVD: code_valid = 1'b0; // RULE18
            default: code_valid = 1'b1;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Registers.

reg [7:0] term_set_reg;
reg [7:0] ctrl_reg;
reg [2:0] cclk_sync_reg;
reg [1:0] cas_sync_reg;
reg cas_s_reg;
reg [1:0] pd_sync_reg;
reg [1:0] sr_sync_reg;
reg [1:0] strap_sync_reg;
reg [LAT_W-1:0] cnt_reg;
reg [LAT_W-1:0] cnt_next;
reg [2:0] state_reg;
reg [2:0] state_next;
reg rd_ack_reg;

wire [2:0] dq_code = term_set_reg[`DOTC_DQ_CODE_MSB:`DOTC_DQ_CODE_LSB];
wire [2:0] ca_code = term_set_reg[`DOTC_CA_CODE_MSB:`DOTC_CA_CODE_LSB];
wire [2:0] bin = ctrl_reg[`DOTC_CTRL_BIN_MSB:`DOTC_CTRL_BIN_LSB];
wire set_b = ctrl_reg[`DOTC_CTRL_WLSET_B];
wire wrlvl = ctrl_reg[`DOTC_CTRL_WRLVL];
wire dq_mode = code_valid(dq_code); // RULE2 RULE3 RULE18
wire low_power = pd_sync_reg[1] | sr_sync_reg[1];
wire cclk_rise = cclk_sync_reg[1] & ~cclk_sync_reg[2];
wire [LAT_W-1:0] lat_on = on_lat(bin, set_b); // RULE9
wire [LAT_W-1:0] lat_off = off_lat(bin, set_b) + (ctrl_reg[`DOTC_CTRL_BL32] ? `DOTC_BL32_EXTRA : 6'h00); // RULE11 RULE12
wire lat_ok = (lat_on != `DOTC_LAT_NA);

wire busy = (state_reg != ST_IDLE);
wire lane_on = (state_reg == ST_ON);
// Gating here drops the lanes in the same cycle as the mode or power change.
wire lane_live = lane_on && dq_mode && !low_power; // RULE7

// A read stalls one cycle so that the registered data stands when the stall drops.
wire rd_pending = avs_read && !rd_ack_reg;
wire bus_stall = (avs_read || avs_write) && !clk_en;

assign avs_waitrequest = rd_pending || bus_stall;

////////////////////////////////////////////////////////////////////////////////
// Register bus.

always @(posedge mclk) begin
    if (srst) begin
        term_set_reg <= `DOTC_TERM_SET_RST; // RULE17
        ctrl_reg <= `DOTC_CTRL_RST;
        avs_readdata <= 32'h0;
        rd_ack_reg <= 1'b0;
    end else if (clk_en) begin
        rd_ack_reg <= rd_pending;
        // Writes to the status and latency words are ignored.
        if (avs_write) begin
            case (avs_address)
                `DOTC_ADDR_TERM_SET: term_set_reg <= avs_writedata[7:0];
                `DOTC_ADDR_CTRL: ctrl_reg <= avs_writedata[7:0];
                default: ;
            endcase
        end
        if (rd_pending) begin
            case (avs_address)
                `DOTC_ADDR_TERM_SET: avs_readdata <= {24'h0, term_set_reg};
                `DOTC_ADDR_CTRL: avs_readdata <= {24'h0, ctrl_reg};
                `DOTC_ADDR_STATUS: avs_readdata <= {27'h0, low_power, busy, lane_on, dq_mode, strap_sync_reg[1]};
                `DOTC_ADDR_LAT: avs_readdata <= {16'h0, 2'h0, lat_off, 2'h0, lat_on};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Synchronisers for pins from the command clock side.

always @(posedge mclk) begin
    if (srst) begin
        cclk_sync_reg <= 3'h0;
        cas_sync_reg <= 2'h0;
        cas_s_reg <= 1'b0;
        pd_sync_reg <= 2'h0;
        sr_sync_reg <= 2'h0;
        strap_sync_reg <= 2'h0;
    end else if (clk_en) begin
        cclk_sync_reg <= {cclk_sync_reg[1:0], cmd_clk};
        cas_sync_reg <= {cas_sync_reg[0], cas2_write};
        cas_s_reg <= cas_sync_reg[1];
        pd_sync_reg <= {pd_sync_reg[0], power_down};
        sr_sync_reg <= {sr_sync_reg[0], self_refresh};
        strap_sync_reg <= {strap_sync_reg[0], cmd_bus_term_strap};
    end
end

////////////////////////////////////////////////////////////////////////////////
// Data lane latency engine, counted in command clock edges.

// A new write command restarts the count in ST_WAIT_ON, so a write during ST_ON turns the lanes off until the new turn-on latency.
always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (!dq_mode || low_power || !lat_ok) begin
        state_next = ST_IDLE; // RULE3 RULE7
        cnt_next = CNT_ZERO;
    end else if (cclk_rise) begin
        if (cas_s_reg) begin
            state_next = ST_WAIT_ON; // RULE5 RULE8 RULE10
            cnt_next = CNT_ONE;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    cnt_next = cnt_reg;
                end
                ST_WAIT_ON: begin
                    cnt_next = cnt_reg + CNT_ONE;
                    if (cnt_reg == lat_on) begin
                        state_next = ST_ON; // RULE8
                    end
                end
                ST_ON: begin
                    cnt_next = cnt_reg + CNT_ONE;
                    if (cnt_reg == lat_off) begin
                        state_next = ST_IDLE; // RULE6 RULE10
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    cnt_next = CNT_ZERO;
                end
            endcase
        end
    end
end

always @(posedge mclk) begin
    if (srst) begin
        state_reg <= ST_IDLE;
        cnt_reg <= CNT_ZERO;
    end else if (clk_en) begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Termination outputs, registered.

always @(posedge mclk) begin
    if (srst) begin
        ca_term_code <= `DOTC_CODE_OFF;
        dq_term_code <= `DOTC_CODE_OFF;
        dqs_term_code_en <= 1'b0;
        dq_term_en <= 1'b0;
        dqs_term_en <= 1'b0;
        mask_inversion_pin_term_en <= 1'b0;
    end else if (clk_en) begin
        ca_term_code <= (strap_sync_reg[1] && code_valid(ca_code)) ? ca_code : `DOTC_CODE_OFF; // RULE1 RULE15
        dq_term_code <= dq_mode ? dq_code : `DOTC_CODE_OFF; // RULE2
        dqs_term_code_en <= dq_mode;
        if (wrlvl) begin
            dq_term_en <= 1'b0; // RULE16
            mask_inversion_pin_term_en <= 1'b0;
            dqs_term_en <= dq_mode && !low_power; // RULE16
        end else begin
            // This single register stage adds one 5 ns clock, past the 3.5 ns end of the analog turn windows.
            dq_term_en <= lane_live; // RULE4 RULE13 RULE14
            dqs_term_en <= lane_live; // RULE4
            mask_inversion_pin_term_en <= lane_live; // RULE4
        end
    end
end

endmodule
`default_nettype wire

//--- hdl/dotc_regs.vh
// Register map, field layout and timing constants of the termination controller.
`ifndef DOTC_REGS_VH
`define DOTC_REGS_VH
`define DOTC_ADDR_TERM_SET 2'h0
`define DOTC_ADDR_CTRL 2'h1
`define DOTC_ADDR_STATUS 2'h2
`define DOTC_ADDR_LAT 2'h3
`define DOTC_TERM_SET_RST 8'h00
`define DOTC_DQ_CODE_LSB 0
`define DOTC_DQ_CODE_MSB 2
`define DOTC_CA_CODE_LSB 4
`define DOTC_CA_CODE_MSB 6
`define DOTC_CODE_OFF 3'h0
`define DOTC_CODE_RSVD 3'h7
`define DOTC_CTRL_RST 8'h00
`define DOTC_CTRL_WLSET_B 0
`define DOTC_CTRL_BIN_LSB 1
`define DOTC_CTRL_BIN_MSB 3
`define DOTC_CTRL_BL32 4
`define DOTC_CTRL_WRLVL 5
`define DOTC_BIN_800 3'h0
`define DOTC_BIN_1066 3'h1
`define DOTC_BIN_1333 3'h2
`define DOTC_BIN_1600 3'h3
`define DOTC_BIN_1866 3'h4
`define DOTC_BIN_2133 3'h5
`define DOTC_LAT_NA 6'h00
`define DOTC_ON_A_1066 6'h04
`define DOTC_ON_A_1333 6'h04
`define DOTC_ON_A_1600 6'h06
`define DOTC_ON_A_1866 6'h06
`define DOTC_ON_A_2133 6'h08
`define DOTC_ON_B_800 6'h06
`define DOTC_ON_B_1066 6'h0C
`define DOTC_ON_B_1333 6'h0E
`define DOTC_ON_B_1600 6'h12
`define DOTC_ON_B_1866 6'h14
`define DOTC_ON_B_2133 6'h18
`define DOTC_OFF_A_1066 6'h14
`define DOTC_OFF_A_1333 6'h16
`define DOTC_OFF_A_1600 6'h18
`define DOTC_OFF_A_1866 6'h1A
`define DOTC_OFF_A_2133 6'h1C
`define DOTC_OFF_B_800 6'h16
`define DOTC_OFF_B_1066 6'h1C
`define DOTC_OFF_B_1333 6'h20
`define DOTC_OFF_B_1600 6'h24
`define DOTC_OFF_B_1866 6'h28
`define DOTC_OFF_B_2133 6'h2C
`define DOTC_BL32_EXTRA 6'h08
`define DOTC_TURN_TIME_MIN_PS 1500
`define DOTC_TURN_TIME_MAX_PS 3500
`define DOTC_CLK_PERIOD_PS 5000
`endif

//--- dv/dotc_monitor.sv
// Port checker for the termination controller.
`timescale 1ns/1ps
`default_nettype none
module dotc_monitor (
    input wire logic mclk,
    input wire logic srst,
    input wire logic clk_en,
    input wire logic power_down,
    input wire logic self_refresh,
    input wire logic cmd_bus_term_strap,
    input wire logic [2:0] ca_term_code,
    input wire logic [2:0] dq_term_code,
    input wire logic dqs_term_code_en,
    input wire logic dq_term_en,
    input wire logic dqs_term_en,
    input wire logic mask_inversion_pin_term_en
);
    default clocking @(posedge mclk); endclocking
    default disable iff (srst);
    a_mode_from_code: assert property (dqs_term_code_en == (dq_term_code != 3'h0))
        else $error("mode flag disagrees with code");
    a_lane_needs_mode: assert property (dq_term_en || dqs_term_en |-> dqs_term_code_en)
        else $error("lane on with mode off");
    a_lane_all_pins: assert property (dq_term_en |-> dqs_term_en && mask_inversion_pin_term_en)
        else $error("lane pins split");
    a_low_power_off: assert property ((power_down || self_refresh) [*4] |-> !dqs_term_en && !dq_term_en)
        else $error("lane on in low power");
    a_strap_low_off: assert property (!cmd_bus_term_strap [*4] |-> ca_term_code == 3'h0)
        else $error("command bus terminated with strap low");
    a_burst_ends: assert property ($rose(dq_term_en) |-> ##[1:1000] !dq_term_en)
        else $error("lane stuck on");
    a_freeze_hold: assert property (!clk_en |=> $stable({ca_term_code, dq_term_en, dqs_term_code_en}))
        else $error("state moved while frozen");
    a_reset_all_off: assert property (disable iff (1'b0) srst |=> ca_term_code == 3'h0 && !dqs_term_en)
        else $error("output on after reset");
endmodule
bind dotc_term_ctrl dotc_monitor u_mon (.*);
`default_nettype wire

//--- dv/dotc_mc_model.sv
// Memory controller model issuing write frames on the command clock.
`timescale 1ns/1ps
`default_nettype none
module dotc_mc_model (
    input wire logic go,
    input wire logic [7:0] ncyc,
    output logic cmd_clk,
    output logic cas2_write
);
    initial begin
        cmd_clk = 1'b0;
        cas2_write = 1'b0;
    end
    // The clock stands still between frames; the command spans the first rising edge.
    always @(posedge go) begin
        #3 cas2_write = 1'b1;
        repeat (ncyc) begin
            #32 cmd_clk = 1'b1;
            #32 cmd_clk = 1'b0;
            cas2_write = 1'b0;
        end
    end
endmodule
`default_nettype wire

//--- dv/dotc_term_ctrl_tb.sv
// Self-checking bench for the termination controller.
`timescale 1ns/1ps
`default_nettype none
module dotc_term_ctrl_tb;
    logic mclk = 1'b0, srst = 1'b1, clk_en = 1'b1, avs_read = 1'b0, avs_write = 1'b0, go = 1'b0;
    logic power_down = 1'b0, self_refresh = 1'b0, cmd_bus_term_strap = 1'b1, b, cmd_clk, cas2_write;
    logic avs_waitrequest, dqs_term_code_en, dq_term_en, dqs_term_en, mask_inversion_pin_term_en;
    logic [1:0] avs_address = 2'h0;
    logic [2:0] ca_term_code, dq_term_code;
    logic [7:0] ncyc = 8'h3C;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, r, exp_q[$];
    integer fail_count = 0, num_checks = 0, seed = 2265, cyc = 0, span = 0, i;
    int on_t[12] = '{0, 4, 4, 6, 6, 8, 6, 12, 14, 18, 20, 24};
    int off_t[12] = '{0, 20, 22, 24, 26, 28, 22, 28, 32, 36, 40, 44};
    always #2.5 mclk = ~mclk;
    dotc_term_ctrl dut (.*);
    dotc_mc_model u_mc (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        num_checks = num_checks + 1;
        if (got !== want) begin
            fail_count = fail_count + 1;
            $display("ERROR %0t: saw %h expected %h", $time, got, want);
        end
    endtask
    task automatic close_out;
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic bus(input logic wr, input logic [1:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) @(posedge mclk);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        r = $random(seed);
        bus(1'b1, a, {r[31:8], d});
    endtask
    task automatic rd(input logic [1:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic burst(input int want);
        @(posedge mclk);
        span = 0;
        go <= 1'b1;
        repeat (820) @(posedge mclk);
        go <= 1'b0;
        chk(span, want);
    endtask
    always @(posedge cmd_clk) if (dq_term_en === 1'b1) span = span + 1;
    // Read data is taken at the edge where the stall is seen low.
    always @(posedge mclk) begin
        if (avs_read && clk_en && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fail_count = fail_count + 1;
            close_out;
        end
    end
    initial begin
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        rd(2'h0, 32'h0);
        chk(ca_term_code, 3'h0);
        for (i = 0; i < 8; i++) begin
            wr(2'h0, {1'b0, i[2:0], 4'h0});
            repeat (4) @(posedge mclk);
            chk(ca_term_code, (i == 7) ? 0 : i);
            rd(2'h0, {1'b0, i[2:0], 4'h0});
        end
        cmd_bus_term_strap <= 1'b0;
        repeat (6) @(posedge mclk);
        chk(ca_term_code, 3'h0);
        cmd_bus_term_strap <= 1'b1;
        for (i = 1; i < 12; i++) begin
            b = $random(seed);
            wr(2'h1, {3'h0, b, 3'(i % 6), i >= 6});
            wr(2'h3, 8'hFF);
            rd(2'h3, {18'h0, 6'(off_t[i] + 8 * b), 2'h0, 6'(on_t[i])});
        end
        wr(2'h1, 8'h02);
        wr(2'h0, 8'h23);
        repeat (4) @(posedge mclk);
        chk({dqs_term_code_en, dq_term_code, dq_term_en}, 5'h16);
        burst(16);
        wr(2'h1, 8'h12);
        burst(24);
        for (i = 1; i < 3; i++) begin
            {power_down, self_refresh} <= i[1:0];
            burst(0);
        end
        {power_down, self_refresh} <= 2'h0;
        wr(2'h0, 8'h20);
        burst(0);
        wr(2'h0, 8'h23);
        wr(2'h1, 8'h22);
        clk_en <= 1'b0;
        repeat (3) @(posedge mclk);
        clk_en <= 1'b1;
        repeat (6) @(posedge mclk);
        chk({dqs_term_en, dq_term_en}, 2'h2);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        repeat (2) @(posedge mclk);
        chk({dqs_term_en, ca_term_code}, 4'h0);
        close_out;
    end
endmodule
`default_nettype wire
